// ---- sim/lvd_cmp_model.sv ----
// Comparator model for the low-voltage detector's far side
module lvd_cmp_model (
    // Clock
    input wire ref_clk,
    // Control
    input wire [4:0] cmp_code,
    input wire cmp_enable,
    input wire [15:0] mv,
    // Result
    output logic cmp_below
);
    timeunit 1ns;
    timeprecision 1ns;
    int tab [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160, 3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
    int th;
    initial cmp_below = 1'b0;
    // Stopped comparator gives no valid level, so it toggles
    always @(posedge ref_clk)
    begin
        th = cmp_code[4] ? 1210 : tab[cmp_code[3:0]];
        cmp_below <= cmp_enable ? (int'(mv) < th) : ~cmp_below;
    end
endmodule

// ---- sim/lvd_ctrl_asserts.sv ----
// Port assertions of the low-voltage detector control
`include "lvd_defines.vh"
module lvd_ctrl_asserts (
    // Clock and resets
    input wire ref_clk,
    input wire sys_rst,
    input wire det_rst,
    // Register access
    input wire [15:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_rd,
    input wire [7:0] cpu_wdata,
    input wire [7:0] cpu_rdata,
    // Detector
    input wire cmp_below,
    input wire [4:0] cmp_code,
    input wire cmp_enable,
    input wire sense_pin_oe,
    input wire detector_reset,
    input wire detector_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    wire wr_ok = cpu_wr && !det_rst;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_irq_one_pulse:
        assert property (detector_irq |=> !detector_irq) else $error("irq pulse too long");
    a_irq_settle_quiet:
        assert property ($rose(cmp_enable) |-> !detector_irq [*8]) else $error("irq while settling");
    a_rst_settle_quiet:
        assert property ($rose(cmp_enable) |-> !detector_reset [*8]) else $error("reset while settling");
    a_rst_needs_enable:
        assert property (detector_reset |-> cmp_enable) else $error("reset while disabled");
    a_rst_release_above:
        assert property (!cmp_below [*4] |=> !detector_reset) else $error("reset held above level");
    a_ext_fixed_code:
        assert property (wr_ok && cpu_addr == `LVD_ADDR_MODE && cpu_wdata[2] |-> ##2 cmp_code == `LVD_EXT_CODE)
        else $error("external code wrong");
    a_level_code_map:
        assert property (wr_ok && cpu_addr == `LVD_ADDR_LEVEL && !cmp_code[4]
            |-> ##2 cmp_code == {1'b0, $past(cpu_wdata[3:0], 2)}) else $error("level code wrong");
    a_enable_copy:
        assert property (wr_ok && cpu_addr == `LVD_ADDR_MODE |-> ##2 cmp_enable == $past(cpu_wdata[7], 2))
        else $error("enable copy wrong");
    a_dir_drives_oe:
        assert property (wr_ok && cpu_addr == `LVD_ADDR_PORTDIR |-> ##2 sense_pin_oe == !$past(cpu_wdata[0], 2))
        else $error("output enable wrong");
    a_read_idle_zero:
        assert property (!cpu_rd |=> cpu_rdata == 8'h00) else $error("read data not idle");
    a_sysrst_quiet:
        assert property ($fell(sys_rst) |-> !(detector_reset || detector_irq || cmp_enable || sense_pin_oe))
        else $error("outputs active after reset");
endmodule
bind lvd_ctrl lvd_ctrl_asserts u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .det_rst(det_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cmp_below(cmp_below), .cmp_code(cmp_code), .cmp_enable(cmp_enable), .sense_pin_oe(sense_pin_oe),
    .detector_reset(detector_reset), .detector_irq(detector_irq));

// ---- sim/tb.sv ----
// Self-checking bench for the low-voltage detector control
`include "lvd_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0;
    logic sys_rst = 1;
    logic det_rst = 0;
    logic cpu_wr = 0;
    logic cpu_rd = 0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata, rv;
    logic [4:0] cmp_code;
    logic cmp_below, cmp_enable, sense_pin_oe, detector_reset, detector_irq;
    int mv = 5000;
    int n_fail = 0;
    int checks = 0;
    int n_irq = 0;
    int base = 0;
    int r;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (detector_irq === 1'b1)
            n_irq <= n_irq + 1;
    lvd_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .det_rst(det_rst), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cmp_below(cmp_below),
        .cmp_code(cmp_code), .cmp_enable(cmp_enable), .sense_pin_oe(sense_pin_oe),
        .detector_reset(detector_reset), .detector_irq(detector_irq));
    lvd_cmp_model i_cmp (.ref_clk(ref_clk), .cmp_code(cmp_code), .cmp_enable(cmp_enable), .mv(mv[15:0]),
        .cmp_below(cmp_below));
    task tick(input int k);
        repeat (k)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1;
        tick(1);
        cpu_wr = 0;
        tick(1);
    endtask
    task rd(input logic [15:0] a);
        cpu_addr = a;
        cpu_rd = 1;
        tick(1);
        cpu_rd = 0;
        rv = cpu_rdata;
        tick(1);
    endtask
    task irq_one;
        tick(8);
        chk("irq count", 8'(n_irq - base), 8'h01);
        base = n_irq;
    endtask
    task finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        finish_test;
    end
    initial
    begin
        void'($urandom(79263));
        r = $urandom % 16;
        tick(5);
        sys_rst = 0;
        rd(`LVD_ADDR_MODE);
        chk("mode", rv, 8'h00);
        rd(`LVD_ADDR_PORTDIR);
        chk("dir", rv, 8'hff);
        rd(`LVD_ADDR_IRQ);
        chk("mask", rv & 8'h02, 8'h02);
        rd(16'hff00);
        chk("unmapped", rv, 8'h00);
        wr(`LVD_ADDR_PORTDIR, 8'hfe);
        chk("oe", {7'h00, sense_pin_oe}, 8'h01);
        wr(`LVD_ADDR_PORTDIR, 8'hff);
        chk("oe", {7'h00, sense_pin_oe}, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            wr(`LVD_ADDR_LEVEL, 8'((i + r) % 16));
            rd(`LVD_ADDR_LEVEL);
            chk("level", rv, 8'((i + r) % 16));
            chk("code", {3'h0, cmp_code}, 8'((i + r) % 16));
        end
        wr(`LVD_ADDR_LEVEL, 8'h05);
        wr(`LVD_ADDR_MODE, 8'h84);
        chk("ext code", {3'h0, cmp_code}, 8'h10);
        chk("enable", {7'h00, cmp_enable}, 8'h01);
        tick(110);
        rd(`LVD_ADDR_MODE);
        chk("flag", rv, 8'h84);
        wr(`LVD_ADDR_IRQ, 8'h00);
        base = n_irq;
        mv = 1000;
        irq_one;
        rd(`LVD_ADDR_MODE);
        chk("flag", rv, 8'h85);
        mv = 2000;
        irq_one;
        mv = 1000;
        irq_one;
        wr(`LVD_ADDR_IRQ, 8'h00);
        wr(`LVD_ADDR_MODE, 8'h00);
        irq_one;
        rd(`LVD_ADDR_IRQ);
        chk("pending", rv, 8'h01);
        rd(`LVD_ADDR_MODE);
        chk("flag off", rv, 8'h00);
        wr(`LVD_ADDR_IRQ, 8'h02);
        mv = 4000;
        wr(`LVD_ADDR_LEVEL, 8'h03);
        wr(`LVD_ADDR_MODE, 8'h80);
        tick(110);
        rd(`LVD_ADDR_MODE);
        chk("flag", rv, 8'h80);
        wr(`LVD_ADDR_MODE, 8'h82);
        tick(8);
        chk("reset", {7'h00, detector_reset}, 8'h00);
        mv = 3500;
        tick(8);
        chk("reset", {7'h00, detector_reset}, 8'h01);
        det_rst = 1;
        tick(2);
        det_rst = 0;
        mv = 4000;
        tick(8);
        chk("reset", {7'h00, detector_reset}, 8'h00);
        rd(`LVD_ADDR_CAUSE);
        chk("cause", rv & 8'h01, 8'h01);
        rd(`LVD_ADDR_IRQ);
        chk("mask", rv & 8'h02, 8'h02);
        rd(`LVD_ADDR_LEVEL);
        chk("level kept", rv, 8'h03);
        rd(`LVD_ADDR_MODE);
        chk("mode kept", rv, 8'h82);
        wr(`LVD_ADDR_MODE, 8'h00);
        wr(`LVD_ADDR_MODE, 8'h84);
        tick(110);
        wr(`LVD_ADDR_MODE, 8'h86);
        mv = 1000;
        tick(8);
        chk("ext reset", {7'h00, detector_reset}, 8'h01);
        mv = 2000;
        tick(8);
        chk("ext reset", {7'h00, detector_reset}, 8'h00);
        sys_rst = 1;
        tick(2);
        sys_rst = 0;
        rd(`LVD_ADDR_LEVEL);
        chk("level clr", rv, 8'h00);
        rd(`LVD_ADDR_MODE);
        chk("mode clr", rv, 8'h00);
        finish_test;
    end
endmodule

// ---- src/lvd_ctrl.v ----
// Low-voltage detector control: registers, threshold select, reset and interrupt generation
`include "lvd_defines.vh"

// Behaviour
// - Level-select register at FFBF; kept on detector reset, cleared on other resets.
// - Four level bits pick sixteen thresholds, code zero highest, fifteen lowest.
// - External source uses fixed internal threshold, level code ignored.
// - Port direction resets to all ones; zero means output, one input.
// - Reset mode, supply source: hold reset while supply below threshold.
// - Reset mode, external source: hold reset while pin below fixed threshold.
// - Interrupt mode raises request on both threshold crossings.
// - While enabled and past the settling count, bit zero of mode register shows below-threshold state.
// - Setting reset mode while source is above threshold gives no reset.
// - A detector reset sets bit zero of the reset-cause register.
// - Every reset sets the detector interrupt mask.
// - Mode register: enable bit7, source bit2, mode bit1, flag bit0; kept on detector reset.
// - Clearing enable while below threshold in interrupt use raises the request.
// - Level flag reads zero while detection is disabled.
module lvd_ctrl (
    // Clock and reset
    input wire ref_clk,
    input wire sys_rst,
    input wire det_rst,
    // CPU register access
    input wire [15:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_rd,
    input wire [7:0] cpu_wdata,
    output reg [7:0] cpu_rdata,
    // Analog comparator
    input wire cmp_below,
    output reg [4:0] cmp_code,
    output reg cmp_enable,
    // Sense pin buffer
    output reg sense_pin_oe,
    // Chip reset and interrupt
    output reg detector_reset,
    output reg detector_irq
);
    reg [7:0] mode_r;
    reg [3:0] threshold_code_r;
    reg [7:0] port12_direction_r;
    reg detector_reset_cause_r;
    reg detector_irq_pending_r;
    reg detector_irq_mask_r;
    reg sync1_r;
    reg sync2_r;
    reg below_r;
    reg [7:0] settle_r;
    reg settled_r;
    reg armed_r;
    reg [7:0] mode_nxt;
    reg irq_evt;
    wire [7:0] mem_rdata;
    wire wr_mode;
    wire wr_level;
    wire wr_dir;
    wire wr_irq;
    wire wr_cause;
    wire detector_enable;
    wire source_select;
    wire reset_or_irq_mode;
    wire below_valid;
    wire below_level_flag;
    wire level_we;
    wire [7:0] level_wdata;
    wire crossing;

    // Full 16-bit compare of CPU address
    function hit;
        input [15:0] a;
        input [15:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign wr_mode = cpu_wr && hit(cpu_addr, `LVD_ADDR_MODE);
    assign wr_level = cpu_wr && hit(cpu_addr, `LVD_ADDR_LEVEL);
    assign wr_dir = cpu_wr && hit(cpu_addr, `LVD_ADDR_PORTDIR);
    assign wr_irq = cpu_wr && hit(cpu_addr, `LVD_ADDR_IRQ);
    assign wr_cause = cpu_wr && hit(cpu_addr, `LVD_ADDR_CAUSE);
    assign level_we = sys_rst || (wr_level && !det_rst);
    assign level_wdata = sys_rst ? `LVD_LEVEL_RST : {4'h0, cpu_wdata[3:0]};
    assign crossing = below_valid && armed_r && (sync2_r != below_r);
    assign detector_enable = mode_r[`LVD_BIT_ENABLE];
    assign source_select = mode_r[`LVD_BIT_SOURCE];
    assign reset_or_irq_mode = mode_r[`LVD_BIT_MODE];
    assign below_valid = detector_enable && settled_r;
    assign below_level_flag = below_valid && below_r;

    // Level-select byte store, read back through its registered port
    lvd_reg8 u_shadow (
        .ref_clk(ref_clk),
        .we(level_we),
        .waddr(2'h0),
        .wdata(level_wdata),
        .raddr(2'h0),
        .rdata(mem_rdata)
    );

    // Comparator synchroniser
    always @(posedge ref_clk)
    begin
        sync1_r <= cmp_below;
        sync2_r <= sync1_r;
    end

    // Settling counter after enable
    // Kept through a detector reset so a looped-back reset stays held
    always @(posedge ref_clk)
    begin
        if (sys_rst || !detector_enable)
        begin
            settle_r <= 8'h00;
            settled_r <= 1'b0;
        end
        else if (settle_r != `LVD_SETTLE_CYCLES)
        begin
            settle_r <= settle_r + 8'h01;
        end
        else
        begin
            settled_r <= 1'b1;
        end
    end

    // Mode register write: flag bit is read-only
    always @*
    begin
        mode_nxt = mode_r;
        if (wr_mode)
        begin
            mode_nxt = {cpu_wdata[7], 4'h0, cpu_wdata[2:1], 1'b0};
        end
    end

    // Interrupt events: crossings and disable while below
    always @*
    begin
        irq_evt = 1'b0;
        if (!reset_or_irq_mode && crossing)
        begin
            irq_evt = 1'b1;
        end
        // Disabling while below counts as an event
        if (!reset_or_irq_mode && below_valid && below_r && !mode_nxt[`LVD_BIT_ENABLE])
        begin
            irq_evt = 1'b1;
        end
    end

    // Configuration: kept on detector reset, loaded with reset values on system reset (direction to all ones)
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mode_r <= `LVD_MODE_RST;
            threshold_code_r <= `LVD_CODE_RST;
            port12_direction_r <= `LVD_PORTDIR_RST;
        end
        else if (!det_rst)
        begin
            mode_r <= mode_nxt;
            if (wr_level)
            begin
                threshold_code_r <= cpu_wdata[3:0];
            end
            if (wr_dir)
            begin
                port12_direction_r <= cpu_wdata;
            end
        end
    end

    // Comparator state tracking; first valid sample only primes the edge detector
    always @(posedge ref_clk)
    begin
        if (sys_rst || !below_valid)
        begin
            below_r <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            below_r <= sync2_r;
            armed_r <= 1'b1;
        end
    end

    // Reset cause, pending and mask flags
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            detector_reset_cause_r <= 1'b0;
            detector_irq_pending_r <= 1'b0;
            detector_irq_mask_r <= 1'b1;
        end
        else if (det_rst)
        begin
            detector_reset_cause_r <= detector_reset_cause_r | detector_reset;
            detector_irq_pending_r <= 1'b0;
            detector_irq_mask_r <= 1'b1;
        end
        else
        begin
            if (detector_reset)
            begin
                detector_reset_cause_r <= 1'b1;
            end
            else if (wr_cause)
            begin
                detector_reset_cause_r <= cpu_wdata[`LVD_BIT_CAUSE];
            end
            // Hardware set wins over a software clear
            if (irq_evt)
            begin
                detector_irq_pending_r <= 1'b1;
            end
            else if (wr_irq)
            begin
                detector_irq_pending_r <= cpu_wdata[`LVD_BIT_PENDING];
            end
            if (wr_irq)
            begin
                detector_irq_mask_r <= cpu_wdata[`LVD_BIT_MASK];
            end
        end
    end

    // Outputs to analog, pins, reset and interrupt logic
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cmp_code <= 5'h00;
            cmp_enable <= 1'b0;
            sense_pin_oe <= 1'b0;
            detector_reset <= 1'b0;
            detector_irq <= 1'b0;
        end
        else
        begin
            cmp_code <= source_select ? `LVD_EXT_CODE : {1'b0, threshold_code_r};
            cmp_enable <= detector_enable;
            sense_pin_oe <= !port12_direction_r[0];
            detector_reset <= reset_or_irq_mode && below_valid && sync2_r;
            // Pulse only when unmasked; pending is set either way
            detector_irq <= irq_evt && !detector_irq_mask_r;
        end
    end

    // Register read path
    always @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cpu_rdata <= 8'h00;
        end
        else
        begin
            if (!cpu_rd)
            begin
                cpu_rdata <= 8'h00;
            end
            else if (hit(cpu_addr, `LVD_ADDR_MODE))
            begin
                // Bit zero of the mode byte is the live flag
                cpu_rdata <= {mode_r[7:1], below_level_flag};
            end
            else if (hit(cpu_addr, `LVD_ADDR_LEVEL))
            begin
                cpu_rdata <= mem_rdata;
            end
            else if (hit(cpu_addr, `LVD_ADDR_PORTDIR))
            begin
                cpu_rdata <= port12_direction_r;
            end
            else if (hit(cpu_addr, `LVD_ADDR_CAUSE))
            begin
                cpu_rdata <= {7'h00, detector_reset_cause_r};
            end
            else if (hit(cpu_addr, `LVD_ADDR_IRQ))
            begin
                cpu_rdata <= {6'h00, detector_irq_mask_r, detector_irq_pending_r};
            end
            else
            begin
                cpu_rdata <= 8'h00;
            end
        end
    end
endmodule

// ---- src/lvd_defines.vh ----
// Register map, field positions and reset values of the low-voltage detector
`ifndef LVD_DEFINES_VH
`define LVD_DEFINES_VH
`define LVD_ADDR_MODE 16'hffbe
`define LVD_ADDR_LEVEL 16'hffbf
`define LVD_ADDR_PORTDIR 16'hff2c
`define LVD_ADDR_CAUSE 16'hffac
`define LVD_ADDR_IRQ 16'hffe0
`define LVD_BIT_ENABLE 7
`define LVD_BIT_SOURCE 2
`define LVD_BIT_MODE 1
`define LVD_BIT_FLAG 0
`define LVD_BIT_CAUSE 0
`define LVD_BIT_PENDING 0
`define LVD_BIT_MASK 1
`define LVD_MODE_RST 8'h00
`define LVD_LEVEL_RST 8'h00
`define LVD_CODE_RST 4'h0
`define LVD_PORTDIR_RST 8'hff
`define LVD_EXT_CODE 5'h10
`define LVD_SETTLE_CYCLES 8'h64
`endif

// ---- src/lvd_reg8.v ----
// Small register file of byte storage with registered read data
module lvd_reg8 (
    // Clock
    input wire ref_clk,
    // Access
    input wire we,
    input wire [1:0] waddr,
    input wire [7:0] wdata,
    input wire [1:0] raddr,
    output reg [7:0] rdata
);
    reg [7:0] mem [0:3];

    always @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        // Write-through keeps a read right after a write current
        if (we && (waddr == raddr))
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end
endmodule
